// [logic/pic_host_pkg.sv]
// Package for the interrupt controller host: constants and carriers
`default_nettype none
package pic_host_pkg;
	// Own register map, byte addresses on APB
	localparam logic [11:0] ADDR_CTRL   = 12'h000;
	localparam logic [11:0] ADDR_WDATA  = 12'h004;
	localparam logic [11:0] ADDR_STATUS = 12'h008;
	localparam logic [11:0] ADDR_RDATA  = 12'h00C;
	localparam logic [11:0] ADDR_VECTOR = 12'h010;
	localparam logic [11:0] ADDR_CONFIG = 12'h014;
	// Control register fields
	localparam int CTRL_GO   = 0;
	localparam int CTRL_RD   = 1;
	localparam int CTRL_SEL  = 2;
	localparam int CTRL_ACK  = 3;
	// Config register fields
	localparam int CFG_FMT   = 0;
	localparam int CFG_BUF   = 1;
	localparam int CFG_MST   = 2;
	// Status register fields
	localparam int STS_BUSY  = 0;
	localparam int STS_INT   = 1;
	localparam int STS_DONE  = 2;
	localparam int STS_BENA  = 3;
	localparam int STS_CAS   = 4;
	// Strobe and setup timing in nanoseconds, rate in MHz
	localparam int CLK_MHZ     = 40;
	localparam int SETUP_NS    = 50;
	localparam int STROBE_NS   = 250;
	localparam int RECOVER_NS  = 200;
	localparam int SETUP_CYC   = (SETUP_NS * CLK_MHZ + 999) / 1000;
	localparam int STROBE_CYC  = (STROBE_NS * CLK_MHZ + 999) / 1000;
	localparam int RECOVER_CYC = (RECOVER_NS * CLK_MHZ + 999) / 1000;
	localparam logic [7:0] CNT_W = 8'h08;
	// Acknowledge pulse counts per processor format
	localparam logic [1:0] ACKS_8BIT  = 2'h3;
	localparam logic [1:0] ACKS_16BIT = 2'h2;
	localparam logic [31:0] RESET_WORD = 32'h00000000;

	// Pins toward the controller device
	typedef struct packed {
		logic       chip_select_n;
		logic       read_n;
		logic       write_n;
		logic       irq_acknowledge_n;
		logic       command_select;
		logic [7:0] data_out;
		logic       data_oe;
	} dev_pins_s;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_SETUP = 3'b001,
		ST_PULSE = 3'b010,
		ST_HOLD  = 3'b011,
		ST_GAP   = 3'b100
	} phase_e;
endpackage
`default_nettype wire

// [logic/pic_host.sv]
// Host that drives the priority interrupt controller through its pins
// Contract
// - Write word sits on the data bus throughout the low write strobe.
// - Command select tied to lowest address bit on byte buses; this host drives it from control bit CTRL_SEL instead.
// - Edge mode: request registers on rising edge, held until acknowledged.
// - Vector bytes come one per acknowledge pulse.
//
// Our own choices: the address map and the APB interface to the registers.
`default_nettype none
module pic_host #(
	parameter int SETUP_CYCLES   = pic_host_pkg::SETUP_CYC,
	parameter int STROBE_CYCLES  = pic_host_pkg::STROBE_CYC,
	parameter int RECOVER_CYCLES = pic_host_pkg::RECOVER_CYC
) (
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	output var  logic        chip_select_n,
	output var  logic        read_n,
	output var  logic        write_n,
	output var  logic        irq_acknowledge_n,
	output var  logic        command_select,
	input  wire logic [7:0]  host_data_bus_in,
	output var  logic [7:0]  host_data_bus_out,
	output var  logic        host_data_bus_oe,
	input  wire logic        device_irq,
	input  wire logic        slave_prog_buf_enable_in,
	output var  logic        slave_prog_buf_enable_out,
	output var  logic        slave_prog_buf_enable_oe,
	input  wire logic [2:0]  cascade_id_lines_in
);
	localparam logic [7:0] SETUP_N   = 8'(SETUP_CYCLES);
	localparam logic [7:0] STROBE_N  = 8'(STROBE_CYCLES);
	localparam logic [7:0] RECOVER_N = 8'(RECOVER_CYCLES);

	pic_host_pkg::phase_e  phase;
	pic_host_pkg::dev_pins_s pins;
	logic [7:0]  timer;
	logic [7:0]  wdata;
	logic [7:0]  rdata;
	logic [23:0] vector;
	logic [1:0]  acks_left;
	logic [1:0]  ack_idx;
	logic        op_read;
	logic        op_sel;
	logic        op_ack;
	logic        done;
	logic [2:0]  cfg;
	logic [2:0]  irq_sync;
	logic        irq_level;
	logic [2:0]  spen_sync;
	logic        spen_level;
	logic [2:0]  cas_s1;
	logic [2:0]  cas_s2;
	logic [2:0]  cas_s3;
	logic [2:0]  cas_level;
	logic        setup_pulse;
	logic        go;
	logic        wr_acc;
	logic        rd_acc;

	// Access phase completes in one cycle; control writes while busy start nothing
	assign wr_acc = psel && penable && pwrite;
	assign rd_acc = psel && !penable && !pwrite;
	assign go = wr_acc && paddr == pic_host_pkg::ADDR_CTRL
		&& pwdata[pic_host_pkg::CTRL_GO]
		&& phase == pic_host_pkg::ST_IDLE;

	// Device pins run asynchronous: three stages, change when 2nd and 3rd agree
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			irq_sync  <= 3'h0;
			irq_level <= 1'b0;
			spen_sync <= 3'h0;
			spen_level <= 1'b0;
			cas_s1 <= 3'h0;
			cas_s2 <= 3'h0;
			cas_s3 <= 3'h0;
			cas_level <= 3'h0;
		end
		else
		begin
			irq_sync  <= {irq_sync[1:0], device_irq};
			spen_sync <= {spen_sync[1:0], slave_prog_buf_enable_in};
			cas_s1 <= cascade_id_lines_in;
			cas_s2 <= cas_s1;
			cas_s3 <= cas_s2;
			if (irq_sync[1] == irq_sync[2])
				irq_level <= irq_sync[2];
			if (spen_sync[1] == spen_sync[2])
				spen_level <= spen_sync[2];
			if (cas_s2 == cas_s3)
				cas_level <= cas_s3;
		end
	end

	// Configuration: format, buffered mode, master strap drive
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			cfg <= 3'h0;
		else if (wr_acc && paddr == pic_host_pkg::ADDR_CONFIG)
			cfg <= pwdata[2:0];
	end

	// Shared pin: in buffered mode the device drives it, else we strap it
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			slave_prog_buf_enable_out <= 1'b1;
			slave_prog_buf_enable_oe  <= 1'b0;
		end
		else
		begin
			slave_prog_buf_enable_oe  <= !cfg[pic_host_pkg::CFG_BUF];
			slave_prog_buf_enable_out <= cfg[pic_host_pkg::CFG_MST];
		end
	end

	// Write data register
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			wdata <= 8'h00;
		else if (wr_acc && paddr == pic_host_pkg::ADDR_WDATA)
			wdata <= pwdata[7:0];
	end

	// Sequencer: setup, strobe low, hold, recovery gap between strobes
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			phase <= pic_host_pkg::ST_IDLE;
			timer <= 8'h00;
			op_read <= 1'b0;
			op_sel <= 1'b0;
			op_ack <= 1'b0;
			acks_left <= 2'h0;
			ack_idx <= 2'h0;
			done <= 1'b0;
			rdata <= 8'h00;
			vector <= 24'h000000;
			pins <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 8'h00, 1'b0};
		end
		else
		begin
			if (rd_acc && paddr == pic_host_pkg::ADDR_STATUS && !go)
				done <= 1'b0;
			case (phase)
				pic_host_pkg::ST_IDLE:
				begin
					if (go)
					begin
						op_read <= pwdata[pic_host_pkg::CTRL_RD];
						op_sel  <= pwdata[pic_host_pkg::CTRL_SEL];
						op_ack  <= pwdata[pic_host_pkg::CTRL_ACK];
						acks_left <= cfg[pic_host_pkg::CFG_FMT]
							? pic_host_pkg::ACKS_16BIT
							: pic_host_pkg::ACKS_8BIT;
						ack_idx <= 2'h0;
						done <= 1'b0;
						if (pwdata[pic_host_pkg::CTRL_ACK])
							vector <= 24'h000000;
						// Select only for read/write, never acknowledge
						pins.chip_select_n <=
							pwdata[pic_host_pkg::CTRL_ACK];
						pins.command_select <=
							pwdata[pic_host_pkg::CTRL_SEL];
						pins.data_out <= wdata;
						pins.data_oe <= !pwdata[pic_host_pkg::CTRL_RD]
							&& !pwdata[pic_host_pkg::CTRL_ACK];
						timer <= SETUP_N;
						phase <= pic_host_pkg::ST_SETUP;
					end
				end
				pic_host_pkg::ST_SETUP:
				begin
					if (timer > 8'h01)
						timer <= timer - 8'h01;
					else
					begin
						if (op_ack)
							pins.irq_acknowledge_n <= 1'b0;
						else if (op_read)
							pins.read_n <= 1'b0;
						else
							pins.write_n <= 1'b0;
						timer <= STROBE_N;
						phase <= pic_host_pkg::ST_PULSE;
					end
				end
				pic_host_pkg::ST_PULSE:
				begin
					if (timer > 8'h01)
						timer <= timer - 8'h01;
					else
					begin
						// Sample before the strobe rises; data valid at end
						if (op_ack)
							vector <= {vector[15:0],
								host_data_bus_in};
						else if (op_read)
							rdata <= host_data_bus_in;
						pins.irq_acknowledge_n <= 1'b1;
						pins.read_n <= 1'b1;
						pins.write_n <= 1'b1;
						timer <= RECOVER_N;
						phase <= pic_host_pkg::ST_HOLD;
					end
				end
				pic_host_pkg::ST_HOLD:
				begin
					// Data held past strobe rise, then bus released
					pins.data_oe <= 1'b0;
					pins.chip_select_n <= 1'b1;
					ack_idx <= ack_idx + 2'h1;
					phase <= pic_host_pkg::ST_GAP;
				end
				default:
				begin
					if (timer > 8'h01)
						timer <= timer - 8'h01;
					else if (op_ack && ack_idx != acks_left)
					begin
						timer <= STROBE_N;
						pins.irq_acknowledge_n <= 1'b0;
						phase <= pic_host_pkg::ST_PULSE;
					end
					else
					begin
						done <= 1'b1;
						phase <= pic_host_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	// Pins straight from flops
	assign chip_select_n     = pins.chip_select_n;
	assign read_n            = pins.read_n;
	assign write_n           = pins.write_n;
	assign irq_acknowledge_n = pins.irq_acknowledge_n;
	assign command_select    = pins.command_select;
	assign host_data_bus_out = pins.data_out;
	assign host_data_bus_oe  = pins.data_oe;

	// APB slave: zero wait states, error on unmapped addresses
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			prdata <= pic_host_pkg::RESET_WORD;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			if (rd_acc)
			begin
				case (paddr)
					pic_host_pkg::ADDR_STATUS:
						prdata <= {25'h0, cas_level, spen_level, done,
							irq_level, phase != pic_host_pkg::ST_IDLE};
					pic_host_pkg::ADDR_RDATA:
						prdata <= {24'h0, rdata};
					pic_host_pkg::ADDR_VECTOR:
						prdata <= {8'h00, vector};
					pic_host_pkg::ADDR_CONFIG:
						prdata <= {29'h0, cfg};
					pic_host_pkg::ADDR_WDATA:
						prdata <= {24'h0, wdata};
					pic_host_pkg::ADDR_CTRL:
						prdata <= pic_host_pkg::RESET_WORD;
					default:
					begin
						prdata <= pic_host_pkg::RESET_WORD;
						pslverr <= 1'b1;
					end
				endcase
			end
			else if (psel && !penable && pwrite)
			begin
				prdata <= pic_host_pkg::RESET_WORD;
				pslverr <= !(paddr == pic_host_pkg::ADDR_CTRL
					|| paddr == pic_host_pkg::ADDR_WDATA
					|| paddr == pic_host_pkg::ADDR_CONFIG);
			end
		end
	end
endmodule
`default_nettype wire

// [verif/pic_host_asserts.sv]
// Checker for the interrupt controller host ports
`default_nettype none
module pic_host_asserts #(
	parameter int STROBE_CYCLES = 4
) (
	input wire logic       clk_sys,
	input wire logic       sys_rst,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pready,
	input wire logic       pslverr,
	input wire logic       chip_select_n,
	input wire logic       read_n,
	input wire logic       write_n,
	input wire logic       irq_acknowledge_n,
	input wire logic       command_select,
	input wire logic [7:0] host_data_bus_out,
	input wire logic       host_data_bus_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] low_cnt;
	wire logic  idle = read_n && write_n && irq_acknowledge_n;
	// Counter, as a strobe may outlast any short repetition
	always_ff @(posedge clk_sys or posedge sys_rst)
		if (sys_rst)
			low_cnt <= 8'h00;
		else
			low_cnt <= idle ? 8'h00 : low_cnt + 8'h01;
	default clocking dc @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);
	a_zero_wait: assert property (psel && !penable |=> pready)
		else $error("pready late");
	a_ready_single: assert property (pready |=> !pready)
		else $error("pready held");
	a_ready_access: assert property (pready |-> psel && penable)
		else $error("pready outside access");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr alone");
	a_strobe_select: assert property (
		!read_n || !write_n |-> !chip_select_n) else $error("no select");
	a_ack_unselected: assert property (
		!irq_acknowledge_n |-> chip_select_n && read_n && write_n)
		else $error("ack with select");
	a_write_held: assert property (
		!write_n |-> host_data_bus_oe && $stable(host_data_bus_out))
		else $error("write data moved");
	a_bus_released: assert property (
		!read_n || !irq_acknowledge_n |-> !host_data_bus_oe)
		else $error("bus clash");
	a_select_steady: assert property (
		!chip_select_n && $past(!chip_select_n) |-> $stable(command_select))
		else $error("select moved");
	a_strobe_width: assert property (
		$rose(idle) |-> low_cnt == STROBE_CYCLES) else $error("bad width");
	c_write: cover property (!write_n ##1 write_n);
	c_read: cover property (!read_n ##1 read_n);
	c_ack: cover property (!irq_acknowledge_n ##1 irq_acknowledge_n);
endmodule
bind pic_host pic_host_asserts #(.STROBE_CYCLES(STROBE_CYCLES))
	pic_host_asserts_inst (.clk_sys, .sys_rst, .psel, .penable, .pready,
	.pslverr, .chip_select_n, .read_n, .write_n, .irq_acknowledge_n,
	.command_select, .host_data_bus_out, .host_data_bus_oe);
`default_nettype wire

// [verif/pic_dev_model.sv]
// Behavioural model of the priority interrupt controller device
`default_nettype none
module pic_dev_model #(
	parameter logic [2:0] CASCADE_ID = 3'h5
) (
	input  wire logic       chip_select_n,
	input  wire logic       read_n,
	input  wire logic       write_n,
	input  wire logic       irq_acknowledge_n,
	input  wire logic       command_select,
	input  wire logic [7:0] host_out,
	input  wire logic       host_oe,
	input  wire logic       request,
	output var  logic [7:0] bus,
	output var  logic       irq,
	output wire logic [2:0] cascade_id_lines
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cmd_word [2];
	logic [7:0] vec_byte = 8'h00;
	logic [1:0] ack_cnt = 2'h0;
	initial irq = 1'b0;
	assign cascade_id_lines = CASCADE_ID;
	// Word taken as the strobe ends, select still valid then
	always @(posedge write_n)
		if (!chip_select_n)
			cmd_word[command_select] = bus;
	always @(posedge request)
		irq = 1'b1;
	// Byte picked as each pulse starts; count wraps after three
	always @(negedge irq_acknowledge_n)
	begin
		vec_byte = ack_cnt == 2'h0 ? 8'hCD : cmd_word[ack_cnt - 2'h1];
		if (ack_cnt == 2'h0)
			irq = 1'b0;
		ack_cnt = ack_cnt == 2'h2 ? 2'h0 : ack_cnt + 2'h1;
	end
	// Released bus flips, so a stale copy never passes for data
	always @(host_oe or host_out or chip_select_n or read_n or
		irq_acknowledge_n or command_select or vec_byte)
		if (host_oe)
			bus = host_out;
		else if (!chip_select_n && !read_n)
			bus = ~cmd_word[command_select];
		else if (!irq_acknowledge_n)
			bus = vec_byte;
		else
			bus = ~bus;
endmodule
`default_nettype wire

// [verif/pic_host_tb.sv]
// Self-checking bench for the interrupt controller host
`default_nettype none
module pic_host_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys = 1'b0;
	logic        sys_rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic        request = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata, q;
	logic [7:0]  host_data_bus_in, host_data_bus_out;
	logic [7:0]  wv [2] = '{8'h3C, 8'h96};
	logic [2:0]  cascade_id_lines_in;
	logic        pready, pslverr, e, chip_select_n, read_n, write_n;
	logic        irq_acknowledge_n, command_select, host_data_bus_oe;
	logic        device_irq, slave_prog_buf_enable_in;
	logic        slave_prog_buf_enable_out, slave_prog_buf_enable_oe;
	int          failures = 0;
	int          samples_checked = 0;
	assign slave_prog_buf_enable_in = slave_prog_buf_enable_oe ?
		slave_prog_buf_enable_out : ~slave_prog_buf_enable_out;
	pic_host #(.SETUP_CYCLES(1), .STROBE_CYCLES(4), .RECOVER_CYCLES(2))
		pic_host_inst (.clk_sys, .sys_rst, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .chip_select_n,
		.read_n, .write_n, .irq_acknowledge_n, .command_select,
		.host_data_bus_in, .host_data_bus_out, .host_data_bus_oe,
		.device_irq, .slave_prog_buf_enable_in, .slave_prog_buf_enable_out,
		.slave_prog_buf_enable_oe, .cascade_id_lines_in);
	pic_dev_model pic_dev_model_inst (.chip_select_n, .read_n, .write_n,
		.irq_acknowledge_n, .command_select, .host_out(host_data_bus_out),
		.host_oe(host_data_bus_oe), .request, .bus(host_data_bus_in),
		.irq(device_irq), .cascade_id_lines(cascade_id_lines_in));
	initial
		forever #12.5 clk_sys = ~clk_sys;
	task automatic report_and_stop;
		$display("checked %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			$display("ERROR %0t got %h expected %h", $time, got, exp);
			failures++;
		end
	endtask
	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (!pready && n < 50);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50)
		begin
			failures++;
			report_and_stop();
		end
	endtask
	// Start a pin sequence and poll until it reports done
	task automatic run(input logic [31:0] c);
		int k;
		k = 0;
		apb(1'b1, pic_host_pkg::ADDR_CTRL, c);
		do
		begin
			apb(1'b0, pic_host_pkg::ADDR_STATUS, 32'h0);
			k++;
		end
		while (q[pic_host_pkg::STS_DONE] !== 1'b1 && k < 60);
		if (k >= 60)
		begin
			failures++;
			report_and_stop();
		end
	endtask
	initial
	begin
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		#1;
		check(32'({chip_select_n, read_n, write_n, irq_acknowledge_n,
			host_data_bus_oe, pready}), 32'h3C);
		apb(1'b1, pic_host_pkg::ADDR_CONFIG, 32'h2);
		repeat (2) @(posedge clk_sys);
		#1;
		check(32'({slave_prog_buf_enable_oe, slave_prog_buf_enable_out}),
			32'h0);
		apb(1'b1, pic_host_pkg::ADDR_CONFIG, 32'h4);
		repeat (6) @(posedge clk_sys);
		apb(1'b0, pic_host_pkg::ADDR_STATUS, 32'h0);
		check(32'(q[6:3]), 32'hB);
		// Both words written before either is read back
		for (int i = 0; i < 2; i++)
		begin
			apb(1'b1, pic_host_pkg::ADDR_WDATA, 32'(wv[i]));
			run(32'h1 | 32'(i << pic_host_pkg::CTRL_SEL));
		end
		for (int i = 0; i < 2; i++)
		begin
			run(32'h3 | 32'(i << pic_host_pkg::CTRL_SEL));
			apb(1'b0, pic_host_pkg::ADDR_RDATA, 32'h0);
			check(q, {24'h000000, ~wv[i]});
		end
		apb(1'b0, 12'h020, 32'h0);
		check(32'(e), 32'h1);
		request <= 1'b1;
		repeat (6) @(posedge clk_sys);
		apb(1'b0, pic_host_pkg::ADDR_STATUS, 32'h0);
		check(32'(q[pic_host_pkg::STS_INT]), 32'h1);
		run(32'h9);
		apb(1'b0, pic_host_pkg::ADDR_VECTOR, 32'h0);
		check(q, 32'h00CD3C96);
		apb(1'b0, pic_host_pkg::ADDR_STATUS, 32'h0);
		check(32'(q[pic_host_pkg::STS_INT]), 32'h0);
		// Sixteen-bit format: two pulses only, so no high address byte
		apb(1'b1, pic_host_pkg::ADDR_CONFIG, 32'h5);
		run(32'h9);
		apb(1'b0, pic_host_pkg::ADDR_VECTOR, 32'h0);
		check(q, 32'h0000CD3C);
		report_and_stop();
	end
endmodule
`default_nettype wire
